// ---- rtl/nvu_defines.svh ----
// register offsets, field positions, keys and timing constants of the nvm sequencer
`ifndef NVU_DEFINES_SVH
`define NVU_DEFINES_SVH
`define NVU_AW 8
`define NVU_OFF_CTRL 8'h00
`define NVU_OFF_KEY 8'h04
`define NVU_OFF_ADRL 8'h08
`define NVU_OFF_ADRH 8'h0C
`define NVU_OFF_DATL 8'h10
`define NVU_OFF_DATH 8'h14
`define NVU_OFF_FLAG 8'h18
`define NVU_OFF_STAT 8'h1C
`define NVU_B_RD 0
`define NVU_B_WR 1
`define NVU_B_WRITE_EN 2
`define NVU_B_FREE 4
`define NVU_B_LWLO 5
`define NVU_B_REGS 6
`define NVU_B_DONE 0
`define NVU_B_IE 1
`define NVU_KEY_FIRST 8'h55
`define NVU_KEY_SECOND 8'hAA
`define NVU_EE_BASE_HI 8'hF0
`define NVU_REG_RST 8'h00
`define NVU_RESP_OKAY 2'b00
`define NVU_RESP_SLVERR 2'b10
`define NVU_CLK_MHZ 20
`define NVU_EE_TIME_US 4000
`define NVU_ERASE_TIME_US 2000
`define NVU_PROG_TIME_US 2000
`define NVU_TMR_W 20
`endif

// ---- rtl/nvu_pkg.sv ----
// types shared by the nvm sequencer modules
package nvu_pkg;
  typedef enum logic [2:0] {OP_IDLE, OP_READ, OP_EE, OP_ERASE, OP_PROG} nvu_op_e;
  typedef enum logic [1:0] {KEY_IDLE, KEY_FIRST, KEY_SECOND} nvu_key_e;
endpackage

// ---- rtl/nvu_op_timer.sv ----
// down-counter that times one nonvolatile operation
`timescale 1ns/10ps
module nvu_op_timer #(
  parameter int W = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // load and status
  input wire logic load,
  input wire logic [W-1:0] cycles,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic done_r;

  assign busy = cnt_r != '0;
  assign done = done_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= cnt_r == W'(1);
      if (load) begin
        cnt_r <= cycles;
      end else if (busy) begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_load;
    load && cycles != '0;
  endsequence

  timer_load_a: assert property (s_load |=> busy && cnt_r == $past(cycles))
    else $error("timer did not take its load");
  timer_done_a: assert property (done |-> $past(cnt_r) == W'(1) && !busy)
    else $error("timer done at wrong count");
endmodule

// ---- rtl/nvu_unlock.sv ----
// tracks the two-key unlock sequence in front of a write start
`timescale 1ns/10ps
`include "nvu_defines.svh"
module nvu_unlock (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register access events
  input wire logic key_wr,
  input wire logic [7:0] key_data,
  input wire logic start_req,
  input wire logic other_acc,
  // unlock granted for this start
  output logic key_ok
);
  nvu_pkg::nvu_key_e state_r;
  nvu_pkg::nvu_key_e state_nxt;

  wire first_key = key_data == `NVU_KEY_FIRST;
  wire second_key = key_data == `NVU_KEY_SECOND;

  assign key_ok = start_req && state_r == nvu_pkg::KEY_SECOND;

  always_comb begin
    state_nxt = state_r;
    if (other_acc || start_req) begin
      state_nxt = nvu_pkg::KEY_IDLE;
    end else if (key_wr) begin
      case (state_r)
        nvu_pkg::KEY_FIRST: state_nxt = second_key ? nvu_pkg::KEY_SECOND :
                                        first_key ? nvu_pkg::KEY_FIRST : nvu_pkg::KEY_IDLE;
        default: state_nxt = first_key ? nvu_pkg::KEY_FIRST : nvu_pkg::KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= nvu_pkg::KEY_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // second key lands while the first is armed; key writes never sit on adjacent clocks
  sequence s_pair;
    state_r == nvu_pkg::KEY_FIRST && key_wr && second_key && !other_acc;
  endsequence

  key_order_a: assert property (s_pair |=> state_r == nvu_pkg::KEY_SECOND)
    else $error("key pair did not arm the unlock");
  key_abort_a: assert property (other_acc |=> !key_ok)
    else $error("unlock survived a foreign access");
  key_once_a: assert property (start_req |=> state_r == nvu_pkg::KEY_IDLE)
    else $error("unlock not consumed by start");
endmodule

// ---- rtl/nvu_top.sv ----
// nvm self-write sequencer with axi4-lite register slave
`timescale 1ns/10ps
`include "nvu_defines.svh"
module nvu_top #(
  parameter int EE_CYCLES = `NVU_EE_TIME_US * `NVU_CLK_MHZ,
  parameter int ERASE_CYCLES = `NVU_ERASE_TIME_US * `NVU_CLK_MHZ,
  parameter int PROG_CYCLES = `NVU_PROG_TIME_US * `NVU_CLK_MHZ
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [`NVU_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`NVU_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // protection pins
  input wire logic nvm_code_protect,
  input wire logic nvm_write_protect,
  // memory array side
  output logic [15:0] mem_addr,
  output logic [13:0] mem_wdata,
  output logic mem_region,
  output logic mem_rd,
  output logic mem_ee_write,
  output logic mem_row_erase,
  output logic mem_latch_load,
  output logic mem_prog,
  input wire logic [13:0] mem_rdata,
  // cpu side
  output logic cpu_stall,
  output logic nvm_irq
);
  function automatic logic nvu_hit(input logic [`NVU_AW-1:0] a, input logic [`NVU_AW-1:0] off);
    return a == off;
  endfunction

  function automatic logic nvu_mapped(input logic [`NVU_AW-1:0] a);
    return a[1:0] == 2'b00 && a <= `NVU_OFF_STAT;
  endfunction

  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [`NVU_AW-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [7:0] adrl_r, adrh_r, datl_r;
  logic [5:0] dath_r;
  logic rd_r, wr_r, write_en_r, free_r, lwlo_r, regs_r, done_r, ie_r;
  logic cp_m_r, cp_s_r, wp_m_r, wp_s_r;
  logic mem_rd_r, mem_ee_r, mem_erase_r, mem_latch_r, mem_prog_r;
  nvu_pkg::nvu_op_e op_r, op_nxt;

  // bus handshake; one write and one read outstanding at most
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  wire wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  wire rd_go = s_axi_arvalid && !rvalid_r;
  wire lane0 = wr_go && wstrb_r[0];
  wire [7:0] wbyte = wdata_r[7:0];
  wire ctrl_wr = lane0 && nvu_hit(awaddr_r, `NVU_OFF_CTRL);
  wire key_wr = lane0 && nvu_hit(awaddr_r, `NVU_OFF_KEY);
  wire flag_wr = lane0 && nvu_hit(awaddr_r, `NVU_OFF_FLAG);
  wire wr_req = ctrl_wr && wbyte[`NVU_B_WR];
  wire rd_req = ctrl_wr && wbyte[`NVU_B_RD];
  wire other_acc = rd_go || (wr_go && !key_wr && !wr_req);
  wire idle = op_r == nvu_pkg::OP_IDLE;
  wire key_ok;

  nvu_unlock nvu_unlock_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .key_wr(key_wr),
    .key_data(wbyte),
    .start_req(wr_req),
    .other_acc(other_acc),
    .key_ok(key_ok)
  );

  // operation select from the control byte being written
  wire is_ee = wbyte[`NVU_B_REGS] && adrh_r == `NVU_EE_BASE_HI;
  wire wp_hit = !wbyte[`NVU_B_REGS] && wp_s_r;
  wire start_ok = key_ok && wbyte[`NVU_B_WRITE_EN] && !cp_s_r && idle;
  wire go_ee = start_ok && is_ee;
  wire go_erase = start_ok && !is_ee && wbyte[`NVU_B_FREE] && !wp_hit;
  wire go_flash = start_ok && !is_ee && !wbyte[`NVU_B_FREE] && !wp_hit;
  wire go_latch = go_flash && wbyte[`NVU_B_LWLO];
  wire go_prog = go_flash && !wbyte[`NVU_B_LWLO];
  wire go_read = rd_req && !wr_req && !cp_s_r && idle;
  wire tmr_load = go_ee || go_erase || go_prog;
  wire [`NVU_TMR_W-1:0] tmr_cycles = go_ee ? `NVU_TMR_W'(EE_CYCLES) :
                                     go_erase ? `NVU_TMR_W'(ERASE_CYCLES) : `NVU_TMR_W'(PROG_CYCLES);
  wire tmr_done;

  nvu_op_timer #(.W(`NVU_TMR_W)) nvu_op_timer_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tmr_load),
    .cycles(tmr_cycles),
    .busy(),
    .done(tmr_done)
  );

  // read data selection
  wire [7:0] ctrl_view = {1'b0, regs_r, lwlo_r, free_r, 1'b0, write_en_r, wr_r, rd_r};
  wire [7:0] flag_view = {6'h00, ie_r, done_r};
  wire [7:0] stat_view = {5'h00, cp_s_r, cpu_stall, !idle};
  wire [7:0] rd_byte = nvu_hit(s_axi_araddr, `NVU_OFF_CTRL) ? ctrl_view :
                       nvu_hit(s_axi_araddr, `NVU_OFF_ADRL) ? adrl_r :
                       nvu_hit(s_axi_araddr, `NVU_OFF_ADRH) ? adrh_r :
                       nvu_hit(s_axi_araddr, `NVU_OFF_DATL) ? datl_r :
                       nvu_hit(s_axi_araddr, `NVU_OFF_DATH) ? {2'b00, dath_r} :
                       nvu_hit(s_axi_araddr, `NVU_OFF_FLAG) ? flag_view :
                       nvu_hit(s_axi_araddr, `NVU_OFF_STAT) ? stat_view : `NVU_REG_RST;

  assign cpu_stall = op_r == nvu_pkg::OP_READ || op_r == nvu_pkg::OP_ERASE ||
                     op_r == nvu_pkg::OP_PROG;
  assign nvm_irq = done_r && ie_r;
  assign mem_addr = {adrh_r, adrl_r};
  assign mem_wdata = {dath_r, datl_r};
  assign mem_region = regs_r;
  assign mem_rd = mem_rd_r;
  assign mem_ee_write = mem_ee_r;
  assign mem_row_erase = mem_erase_r;
  assign mem_latch_load = mem_latch_r;
  assign mem_prog = mem_prog_r;

  always_comb begin
    op_nxt = op_r;
    case (op_r)
      nvu_pkg::OP_IDLE: begin
        if (go_read) begin
          op_nxt = nvu_pkg::OP_READ;
        end else if (go_ee) begin
          op_nxt = nvu_pkg::OP_EE;
        end else if (go_erase) begin
          op_nxt = nvu_pkg::OP_ERASE;
        end else if (go_prog) begin
          op_nxt = nvu_pkg::OP_PROG;
        end
      end
      nvu_pkg::OP_READ: op_nxt = nvu_pkg::OP_IDLE;
      default: begin
        if (tmr_done) begin
          op_nxt = nvu_pkg::OP_IDLE;
        end
      end
    endcase
  end

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {cp_m_r, cp_s_r, wp_m_r, wp_s_r} <= 4'h0;
    end else begin
      {cp_m_r, cp_s_r, wp_m_r, wp_s_r} <= {nvm_code_protect, cp_m_r, nvm_write_protect, wp_m_r};
    end
  end

  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `NVU_RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= nvu_mapped(awaddr_r) ? `NVU_RESP_OKAY : `NVU_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `NVU_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= nvu_mapped(s_axi_araddr) ? `NVU_RESP_OKAY : `NVU_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // control, status and data registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {rd_r, wr_r, write_en_r, free_r, lwlo_r, regs_r, done_r, ie_r} <= `NVU_REG_RST;
      {adrl_r, adrh_r, datl_r} <= 24'h00_0000;
      dath_r <= 6'h00;
      op_r <= nvu_pkg::OP_IDLE;
    end else begin
      op_r <= op_nxt;
      if (ctrl_wr) begin
        write_en_r <= wbyte[`NVU_B_WRITE_EN];
        free_r <= wbyte[`NVU_B_FREE];
        lwlo_r <= wbyte[`NVU_B_LWLO];
        regs_r <= wbyte[`NVU_B_REGS];
      end
      rd_r <= go_read;
      if (tmr_load) begin
        wr_r <= 1'b1;
      end else if (tmr_done) begin
        wr_r <= 1'b0;
      end
      if (tmr_done) begin
        done_r <= 1'b1;
      end else if (flag_wr && wbyte[`NVU_B_DONE]) begin
        done_r <= 1'b0;
      end
      if (flag_wr) begin
        ie_r <= wbyte[`NVU_B_IE];
      end
      if (lane0 && nvu_hit(awaddr_r, `NVU_OFF_ADRL)) begin
        adrl_r <= wbyte;
      end
      if (lane0 && nvu_hit(awaddr_r, `NVU_OFF_ADRH)) begin
        adrh_r <= wbyte;
      end
      if (op_r == nvu_pkg::OP_READ) begin
        {dath_r, datl_r} <= mem_rdata;
      end else begin
        if (lane0 && nvu_hit(awaddr_r, `NVU_OFF_DATL)) begin
          datl_r <= wbyte;
        end
        if (lane0 && nvu_hit(awaddr_r, `NVU_OFF_DATH)) begin
          dath_r <= wbyte[5:0];
        end
      end
    end
  end

  // one-cycle commands to the array
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {mem_rd_r, mem_ee_r, mem_erase_r, mem_latch_r, mem_prog_r} <= 5'h00;
    end else begin
      {mem_rd_r, mem_ee_r, mem_erase_r, mem_latch_r, mem_prog_r} <=
        {go_read, go_ee, go_erase, go_latch, go_prog};
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ee_start;
    go_ee ##1 op_r == nvu_pkg::OP_EE;
  endsequence

  unlock_gate_a: assert property ((mem_ee_r || mem_erase_r || mem_latch_r || mem_prog_r) |-> $past(key_ok))
    else $error("array operation without unlock");
  protect_gate_a: assert property ((mem_rd_r || mem_ee_r || mem_erase_r || mem_prog_r) |-> !$past(cp_s_r))
    else $error("array access while code-protected");
  ee_runs_a: assert property (s_ee_start |-> !cpu_stall && wr_r)
    else $error("eeprom write stalled or start low");
  ee_hold_a: assert property (op_r == nvu_pkg::OP_EE && ctrl_wr && !tmr_done |=> wr_r)
    else $error("software cleared start during eeprom write");
  done_set_a: assert property (tmr_done |=> done_r && !wr_r && op_r == nvu_pkg::OP_IDLE)
    else $error("completion did not set done");
  wp_refuse_a: assert property (wr_req && key_ok && wp_hit && !is_ee && idle |=> !wr_r && !mem_erase_r)
    else $error("protected erase was started");
  bad_start_a: assert property (wr_req && !(key_ok && wbyte[`NVU_B_WRITE_EN]) && idle |=> !wr_r)
    else $error("start without unlock took effect");
  read_data_a: assert property (op_r == nvu_pkg::OP_READ |=> {dath_r, datl_r} == $past(mem_rdata) && !rd_r)
    else $error("read data not captured");
  wen_keep_a: assert property (tmr_done && !ctrl_wr |=> write_en_r == $past(write_en_r))
    else $error("operation changed write enable");
endmodule

// ---- verification/tb_nvm_unlock_write_erase.sv ----
// self-checking bench for the nvm self-write sequencer
`timescale 1ns/10ps
`include "nvu_defines.svh"
module tb_nvm_unlock_write_erase;
  localparam int EE_N = 20;
  localparam int ER_N = 10;
  localparam int PG_N = 10;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic code_prot = 1'b0;
  logic wr_prot = 1'b0;
  logic [13:0] mem_rdata = 14'h2A5C;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] mem_addr;
  logic [13:0] mem_wdata;
  logic mem_region, mem_rd, mem_ee_write, mem_row_erase, mem_latch_load, mem_prog, cpu_stall, nvm_irq;
  logic [31:0] mismatches = 32'h0000_0000;
  logic [31:0] checks = 32'h0000_0000;
  logic [31:0] n_ee = 32'h0000_0000;
  logic [31:0] n_er = 32'h0000_0000;
  logic [31:0] n_ll = 32'h0000_0000;
  logic [31:0] n_pg = 32'h0000_0000;
  logic [31:0] n_rd = 32'h0000_0000;
  logic [31:0] n_st = 32'h0000_0000;
  logic [31:0] cyc = 32'h0000_0000;
  logic [31:0] rd_v, s0, e0;

  nvu_top #(.EE_CYCLES(EE_N), .ERASE_CYCLES(ER_N), .PROG_CYCLES(PG_N)) nvu_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .nvm_code_protect(code_prot), .nvm_write_protect(wr_prot),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_region(mem_region), .mem_rd(mem_rd),
    .mem_ee_write(mem_ee_write), .mem_row_erase(mem_row_erase), .mem_latch_load(mem_latch_load),
    .mem_prog(mem_prog), .mem_rdata(mem_rdata), .cpu_stall(cpu_stall), .nvm_irq(nvm_irq)
  );

  initial begin
    forever #25 aclk = ~aclk;
  end

  // pulse and stall counters, plus the hang limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (mem_ee_write === 1'b1) n_ee <= n_ee + 1;
    if (mem_row_erase === 1'b1) n_er <= n_er + 1;
    if (mem_latch_load === 1'b1) n_ll <= n_ll + 1;
    if (mem_prog === 1'b1) n_pg <= n_pg + 1;
    if (mem_rd === 1'b1) n_rd <= n_rd + 1;
    if (cpu_stall === 1'b1) n_st <= n_st + 1;
    if (cyc === 32'h0000_4E20) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks != 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic unlock(input logic [31:0] c);
    axi_wr(`NVU_OFF_KEY, 32'h0000_0055);
    axi_wr(`NVU_OFF_KEY, 32'h0000_00AA);
    axi_wr(`NVU_OFF_CTRL, c);
  endtask

  // poll a register until the masked value matches
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    axi_rd(a);
    for (int i = 0; i < 100 && (rd_v & m) !== v; i++) axi_rd(a);
  endtask

  task automatic try_start(input logic [31:0] c, input logic [31:0] exp);
    axi_wr(`NVU_OFF_CTRL, c);
    axi_rd(`NVU_OFF_CTRL);
    check(rd_v, exp);
  endtask

  task automatic t_reset();
    axi_rd(`NVU_OFF_CTRL);
    check(rd_v, 32'h0000_0000);
    check({30'h0000_0000, cpu_stall, nvm_irq}, 32'h0000_0000);
    axi_wr(8'h20, 32'h0000_0055);
    check({30'h0000_0000, rsp}, {30'h0000_0000, `NVU_RESP_SLVERR});
    axi_rd(8'h22);
    check({rd_v[31:2], rsp}, {30'h0000_0000, `NVU_RESP_SLVERR});
  endtask

  task automatic t_eeprom();
    axi_wr(`NVU_OFF_FLAG, 32'h0000_0003);
    axi_wr(`NVU_OFF_ADRH, 32'h0000_00F0);
    axi_wr(`NVU_OFF_ADRL, 32'h0000_0012);
    axi_wr(`NVU_OFF_DATL, 32'h0000_005A);
    axi_wr(`NVU_OFF_DATH, 32'h0000_0015);
    axi_wr(`NVU_OFF_CTRL, 32'h0000_0044);
    s0 = n_st;
    unlock(32'h0000_0046);
    axi_rd(`NVU_OFF_CTRL);
    check(rd_v & 32'h0000_0002, 32'h0000_0002);
    check({16'h0000, mem_addr}, 32'h0000_F012);
    check({18'h0000, mem_wdata}, 32'h0000_155A);
    check({31'h0000_0000, mem_region}, 32'h0000_0001);
    axi_wr(`NVU_OFF_CTRL, 32'h0000_0044);
    axi_rd(`NVU_OFF_CTRL);
    check(rd_v & 32'h0000_0002, 32'h0000_0002);
    poll(`NVU_OFF_CTRL, 32'h0000_0002, 32'h0000_0000);
    check(rd_v, 32'h0000_0044);
    check(n_ee, 32'h0000_0001);
    check(n_er, 32'h0000_0000);
    check(n_st - s0, 32'h0000_0000);
    axi_rd(`NVU_OFF_FLAG);
    check({rd_v[30:0], nvm_irq}, 32'h0000_0007);
    axi_wr(`NVU_OFF_FLAG, 32'h0000_0001);
    check({31'h0000_0000, nvm_irq}, 32'h0000_0000);
  endtask

  task automatic t_erase();
    axi_wr(`NVU_OFF_FLAG, 32'h0000_0003);
    axi_wr(`NVU_OFF_ADRH, 32'h0000_0000);
    axi_wr(`NVU_OFF_ADRL, 32'h0000_0040);
    axi_wr(`NVU_OFF_CTRL, 32'h0000_0014);
    s0 = n_st;
    unlock(32'h0000_0016);
    check({31'h0000_0000, cpu_stall}, 32'h0000_0001);
    check({31'h0000_0000, mem_region}, 32'h0000_0000);
    poll(`NVU_OFF_FLAG, 32'h0000_0001, 32'h0000_0001);
    check(n_er, 32'h0000_0001);
    check(n_st - s0, ER_N + 1);
    check(n_ll, 32'h0000_0000);
    check({31'h0000_0000, nvm_irq}, 32'h0000_0001);
    axi_rd(`NVU_OFF_CTRL);
    check(rd_v, 32'h0000_0014);
    axi_wr(`NVU_OFF_FLAG, 32'h0000_0003);
  endtask

  task automatic t_protect();
    wr_prot <= 1'b1;
    axi_wr(`NVU_OFF_FLAG, 32'h0000_0003);
    unlock(32'h0000_0016);
    axi_rd(`NVU_OFF_CTRL);
    check(rd_v, 32'h0000_0014);
    check(n_er, 32'h0000_0001);
    axi_rd(`NVU_OFF_FLAG);
    check(rd_v & 32'h0000_0001, 32'h0000_0000);
    wr_prot <= 1'b0;
  endtask

  task automatic t_broken();
    axi_wr(`NVU_OFF_KEY, 32'h0000_0055);
    axi_rd(`NVU_OFF_FLAG);
    axi_wr(`NVU_OFF_KEY, 32'h0000_00AA);
    try_start(32'h0000_0016, 32'h0000_0014);
    axi_wr(`NVU_OFF_KEY, 32'h0000_00AA);
    axi_wr(`NVU_OFF_KEY, 32'h0000_0055);
    try_start(32'h0000_0016, 32'h0000_0014);
    axi_wr(`NVU_OFF_KEY, 32'h0000_0055);
    axi_wr(`NVU_OFF_KEY, 32'h0000_00AA);
    try_start(32'h0000_0012, 32'h0000_0010);
    axi_wr(`NVU_OFF_CTRL, 32'h0000_0014);
    axi_wr(`NVU_OFF_KEY, 32'h0000_0055);
    axi_wr(`NVU_OFF_KEY, 32'h0000_00AA);
    axi_wr(`NVU_OFF_ADRL, 32'h0000_0040);
    try_start(32'h0000_0016, 32'h0000_0014);
    check(n_er + n_ll + n_pg, 32'h0000_0001);
  endtask

  task automatic t_prog();
    axi_wr(`NVU_OFF_ADRL, 32'h0000_0080);
    axi_wr(`NVU_OFF_CTRL, 32'h0000_0024);
    unlock(32'h0000_0026);
    axi_rd(`NVU_OFF_CTRL);
    check(rd_v, 32'h0000_0024);
    check(n_ll, 32'h0000_0001);
    axi_wr(`NVU_OFF_CTRL, 32'h0000_0004);
    s0 = n_st;
    unlock(32'h0000_0006);
    poll(`NVU_OFF_FLAG, 32'h0000_0001, 32'h0000_0001);
    check(n_pg, 32'h0000_0001);
    check(n_er, 32'h0000_0001);
    check(n_st - s0, PG_N + 1);
    axi_wr(`NVU_OFF_FLAG, 32'h0000_0003);
  endtask

  task automatic t_read();
    axi_wr(`NVU_OFF_ADRL, 32'h0000_0033);
    s0 = n_st;
    e0 = n_rd;
    axi_wr(`NVU_OFF_CTRL, 32'h0000_0001);
    mem_rdata <= 14'h0111;
    axi_rd(`NVU_OFF_CTRL);
    check(rd_v, 32'h0000_0000);
    check(n_rd - e0, 32'h0000_0001);
    check(n_st - s0, 32'h0000_0001);
    axi_rd(`NVU_OFF_DATL);
    check(rd_v, 32'h0000_005C);
    axi_rd(`NVU_OFF_DATH);
    check(rd_v, 32'h0000_002A);
  endtask

  task automatic t_code_protect();
    code_prot <= 1'b1;
    axi_wr(`NVU_OFF_ADRH, 32'h0000_00F0);
    axi_wr(`NVU_OFF_CTRL, 32'h0000_0044);
    e0 = n_rd;
    unlock(32'h0000_0046);
    axi_rd(`NVU_OFF_CTRL);
    check(rd_v, 32'h0000_0044);
    axi_wr(`NVU_OFF_CTRL, 32'h0000_0041);
    axi_rd(`NVU_OFF_CTRL);
    check(rd_v, 32'h0000_0040);
    check(n_ee, 32'h0000_0001);
    check(n_rd - e0, 32'h0000_0000);
    axi_rd(`NVU_OFF_STAT);
    check(rd_v, 32'h0000_0004);
    code_prot <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_eeprom();
    t_erase();
    t_protect();
    t_broken();
    t_prog();
    t_read();
    t_code_protect();
    conclude();
  end
endmodule
